// file: cxm_host.sv
// Function
// RULE1: Mode-select low fast, high standby.
// RULE2: Fast mode keeps edges unlimited.
// RULE3: Slope resistor to ground sets edges.
// RULE4: Standby: driver off, receiver listening.
// RULE5: Standby same with or without resistor.
// RULE6: Dominant edge in standby may wake device.
// RULE7: Driver returns when mode-select goes low.
// RULE8: Loopback on: driver off, bus idle.
// RULE9: Loopback keeps bus receive path alive.
// RULE10: Loopback feeds transmit data to receive.
// RULE11: Loopback error frames stay off bus.
// RULE12: Search starts at 125 kbps, waits.
// RULE13: Status tells good message from warning.
// RULE14: On warning step rate, wait again.
// RULE15: Rate found: loopback low, normal traffic.
// RULE16: Loopback input pulled low inside.
// RULE17: Overheat cuts driver current only.
// RULE18: Bus rates up to 1 Mbps; the rate search here wraps after 500 kbps.
// RULE19: Loopback receive is AND of both.
// RULE20: Disabled driver leaves bus recessive.
`timescale 1ns/100ps

module cxm_host (
    input  wire logic                 CLK,                      // 25 MHz clock
    input  wire logic                 RST,                      // Async, high
    input  wire logic                 TX_BIT,                   // Protocol engine bit
    input  wire logic                 STANDBY_REQ,              // Pulse: go standby
    input  wire logic                 WAKE_REQ,                 // Pulse: leave standby
    input  wire logic                 WAKE_ON_BUS,              // Level: bus may wake
    input  wire logic                 AUTOBAUD_START,           // Pulse: start search
    input  wire logic                 MSG_OK,                   // Pulse: valid message
    input  wire logic                 ERR_WARN,                 // Pulse: error counted
    input  wire logic                 RXD,                      // Receive pin
    input  wire logic                 RX_EVT_READY,             // User takes event
    output logic                      TXD,                      // Transmit pin
    output logic                      MODE_SELECT_IN,           // Mode-select pin
    output logic                      AUTOBAUD_LOOP_SELECT_IN,  // Loopback pin
    output logic                      TX_READY,                 // Bits reach the pin
    output logic [1:0]                RATE_IDX,                 // Candidate rate
    output logic [15:0]               RATE_KBPS,                // Candidate in kbps
    output logic                      RATE_LOCKED,              // Search succeeded
    output cxm_pkg::cxm_state_t       STATE,                    // Controller state
    output logic                      RX_EVT_VALID,             // Event waiting
    output cxm_pkg::cxm_rx_evt_t      RX_EVT                    // Event contents
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Next search candidate, wrapping so the search never stalls
    function automatic logic [1:0] next_rate(input logic [1:0] idx);
        next_rate = (idx == cxm_pkg::RATE_IDX_LAST) ? cxm_pkg::RATE_IDX_FIRST
                                                   : 2'(idx + 2'h1);
    endfunction

    // Candidate index to its rate in kbps
    function automatic logic [15:0] rate_of(input logic [1:0] idx);
        case (idx)
            2'h0:    rate_of = cxm_pkg::RATE_125K;
            2'h1:    rate_of = cxm_pkg::RATE_250K;
            2'h2:    rate_of = cxm_pkg::RATE_500K;
            default: rate_of = cxm_pkg::RATE_1M;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    cxm_pkg::cxm_state_t              state_r;       // Current mode
    cxm_pkg::cxm_state_t              state_nxt;     // Next mode
    logic [cxm_pkg::WAKE_CNT_W-1:0]   wake_cnt_r;    // Wake wait counter
    logic [1:0]                       rate_idx_r;    // Candidate index
    logic [1:0]                       rate_idx_nxt;
    logic                             locked_r;      // Search result
    logic                             last_rxd_r;    // Last level handed on
    logic                             rx_dom_edge;   // Recessive to dominant
    logic                             in_valid;      // New transition seen
    logic                             in_ready;      // Buffer has room
    logic                             push;
    logic                             pop;
    cxm_pkg::cxm_rx_evt_t             in_evt;
    cxm_pkg::cxm_rx_evt_t             spare_r;       // Second buffer entry
    logic                             spare_valid_r;
    logic                             drive_ok;      // Transmit data may pass

    // Edge seen on the raw pin, not gated by buffer room
    assign rx_dom_edge    = (RXD == cxm_pkg::LVL_DOMINANT) &&
                            (last_rxd_r == cxm_pkg::LVL_RECESSIVE);
    assign in_valid       = (RXD != last_rxd_r);
    assign in_ready       = !spare_valid_r;
    assign push           = in_valid && in_ready;
    assign pop            = RX_EVT_VALID && RX_EVT_READY;
    assign in_evt.level   = RXD;
    assign in_evt.dom_edge = rx_dom_edge;

    // ------------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------------
    // Next state; search results win over a new request in the same cycle
    always_comb begin
        state_nxt    = state_r;
        rate_idx_nxt = rate_idx_r;
        case (state_r)
            cxm_pkg::CXM_NORMAL: begin
                if (AUTOBAUD_START) begin
                    state_nxt    = cxm_pkg::CXM_AUTOBAUD;     // [RULE12]
                    rate_idx_nxt = cxm_pkg::RATE_IDX_FIRST;   // [RULE12]
                end else if (STANDBY_REQ) begin
                    state_nxt = cxm_pkg::CXM_STANDBY;         // [RULE1]
                end
            end
            cxm_pkg::CXM_STANDBY: begin
                // Bus activity or software brings the driver back
                if (WAKE_REQ || (WAKE_ON_BUS && rx_dom_edge)) begin
                    state_nxt = cxm_pkg::CXM_WAKE;            // [RULE6]
                end
            end
            cxm_pkg::CXM_WAKE: begin
                // Driver needs its wake time before bits are trusted
                if (wake_cnt_r == cxm_pkg::WAKE_LAST) begin
                    state_nxt = cxm_pkg::CXM_NORMAL;          // [RULE6]
                end
            end
            cxm_pkg::CXM_AUTOBAUD: begin
                if (MSG_OK) begin
                    state_nxt = cxm_pkg::CXM_NORMAL;          // [RULE15]
                end else if (ERR_WARN) begin
                    rate_idx_nxt = next_rate(rate_idx_r);     // [RULE14]
                end
            end
            default: begin
                state_nxt = cxm_pkg::CXM_NORMAL;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= cxm_pkg::CXM_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wake wait counter, cleared outside the wake state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_cnt_r <= '0;
        end else if (state_r == cxm_pkg::CXM_WAKE) begin
            wake_cnt_r <= wake_cnt_r + 1'b1;
        end else begin
            wake_cnt_r <= '0;
        end
    end

    // Rate search bookkeeping
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rate_idx_r <= cxm_pkg::RATE_IDX_FIRST;
            locked_r   <= 1'b0;
        end else begin
            rate_idx_r <= rate_idx_nxt;
            if (state_r == cxm_pkg::CXM_AUTOBAUD && MSG_OK) begin
                locked_r <= 1'b1;                             // [RULE13]
            end else if (state_r == cxm_pkg::CXM_NORMAL && AUTOBAUD_START) begin
                locked_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    // Bits pass only while the driver is awake; loopback mode still passes
    // them so the local engine hears itself without touching the bus
    assign drive_ok = (state_nxt == cxm_pkg::CXM_NORMAL) ||
                      (state_nxt == cxm_pkg::CXM_AUTOBAUD);

    // Registered pins and status, all from the next state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TXD                     <= cxm_pkg::LVL_RECESSIVE;
            MODE_SELECT_IN          <= cxm_pkg::MODE_FAST;
            AUTOBAUD_LOOP_SELECT_IN <= cxm_pkg::LOOP_OFF;
            TX_READY                <= 1'b0;
            RATE_IDX                <= cxm_pkg::RATE_IDX_FIRST;
            RATE_KBPS               <= cxm_pkg::RATE_125K;
            RATE_LOCKED             <= 1'b0;
            STATE                   <= cxm_pkg::CXM_NORMAL;
        end else begin
            TXD            <= drive_ok ? TX_BIT : cxm_pkg::LVL_RECESSIVE;
            // Standby is the only high level; wake already drives low
            // A firm low selects full speed, so the edges are not slope-limited
            MODE_SELECT_IN <= (state_nxt == cxm_pkg::CXM_STANDBY) ?
                              cxm_pkg::MODE_STANDBY : cxm_pkg::MODE_FAST;   // [RULE1] [RULE2]
            AUTOBAUD_LOOP_SELECT_IN <= (state_nxt == cxm_pkg::CXM_AUTOBAUD) ?
                                       cxm_pkg::LOOP_ON : cxm_pkg::LOOP_OFF; // [RULE15]
            TX_READY       <= drive_ok;
            RATE_IDX       <= rate_idx_nxt;
            RATE_KBPS      <= rate_of(rate_idx_nxt);
            RATE_LOCKED    <= (state_r == cxm_pkg::CXM_AUTOBAUD && MSG_OK) ? 1'b1 :
                              (state_r == cxm_pkg::CXM_NORMAL && AUTOBAUD_START) ?
                              1'b0 : locked_r;
            STATE          <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Receive event buffer
    // ------------------------------------------------------------------------
    // Two entries; when full the last level is frozen so the pending
    // transition is delivered later instead of dropped
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            last_rxd_r <= cxm_pkg::LVL_RECESSIVE;
        end else if (push) begin
            last_rxd_r <= RXD;
        end
    end

    // Head entry is the output itself, spare behind it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RX_EVT_VALID  <= 1'b0;
            RX_EVT        <= '0;
            spare_valid_r <= 1'b0;
            spare_r       <= '0;
        end else if (pop) begin
            if (spare_valid_r) begin
                RX_EVT        <= spare_r;
                spare_valid_r <= 1'b0;
            end else begin
                RX_EVT_VALID <= push;
                RX_EVT       <= push ? in_evt : RX_EVT;
            end
        end else if (push) begin
            if (!RX_EVT_VALID) begin
                RX_EVT_VALID <= 1'b1;
                RX_EVT       <= in_evt;
            end else begin
                spare_valid_r <= 1'b1;
                spare_r       <= in_evt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    localparam int WAKE_MAX = 39;

    sequence s_bus_wake;
        STATE == cxm_pkg::CXM_STANDBY && WAKE_ON_BUS && rx_dom_edge && !RST;
    endsequence

    sequence s_lock;
        state_r == cxm_pkg::CXM_AUTOBAUD && MSG_OK;
    endsequence

    AST_BUS_WAKE: assert property (@(posedge CLK) disable iff (RST)  // [RULE6]
        s_bus_wake |=> (MODE_SELECT_IN == cxm_pkg::MODE_FAST) && !TX_READY)
        else $error("Bus wake did not lower mode select");

    AST_WAKE_DONE: assert property (@(posedge CLK) disable iff (RST)  // [RULE6]
        s_bus_wake |=> (TXD == cxm_pkg::LVL_RECESSIVE)[*8] ##[1:WAKE_MAX] TX_READY)
        else $error("Wake wait wrong length");

    AST_AB_START: assert property (@(posedge CLK) disable iff (RST)  // [RULE12]
        (STATE == cxm_pkg::CXM_NORMAL && AUTOBAUD_START) |=>
        AUTOBAUD_LOOP_SELECT_IN && RATE_IDX == cxm_pkg::RATE_IDX_FIRST && !RATE_LOCKED)
        else $error("Search did not start at first rate");

    AST_AB_WAIT: assert property (@(posedge CLK) disable iff (RST)  // [RULE12]
        (STATE == cxm_pkg::CXM_AUTOBAUD && !MSG_OK && !ERR_WARN) |=>
        $stable(RATE_IDX) && AUTOBAUD_LOOP_SELECT_IN)
        else $error("Rate moved without a status event");

    AST_ERR_STEP: assert property (@(posedge CLK) disable iff (RST)  // [RULE14]
        (STATE == cxm_pkg::CXM_AUTOBAUD && ERR_WARN && !MSG_OK) |=>
        RATE_IDX == next_rate($past(RATE_IDX)) && RATE_KBPS == rate_of(RATE_IDX))
        else $error("Warning did not step the rate");

    AST_MSG_LOCK: assert property (@(posedge CLK) disable iff (RST)  // [RULE13]
        s_lock |=> RATE_LOCKED && $stable(RATE_IDX))
        else $error("Valid message did not lock the rate");

    AST_AB_RELEASE: assert property (@(posedge CLK) disable iff (RST)  // [RULE15]
        s_lock |=> (!AUTOBAUD_LOOP_SELECT_IN && TX_READY &&
                    MODE_SELECT_IN == cxm_pkg::MODE_FAST)[*2])
        else $error("Loopback not released after lock");

    AST_STANDBY_IDLE: assert property (@(posedge CLK) disable iff (RST)  // [RULE1]
        (STATE == cxm_pkg::CXM_STANDBY) |->
        MODE_SELECT_IN == cxm_pkg::MODE_STANDBY && TXD == cxm_pkg::LVL_RECESSIVE)
        else $error("Standby pins wrong");

    AST_RX_HOLD: assert property (@(posedge CLK) disable iff (RST)  // [RULE6]
        (RX_EVT_VALID && !RX_EVT_READY) |=> RX_EVT_VALID && $stable(RX_EVT))
        else $error("Receive event changed while stalled");

endmodule // cxm_host

// file: cxm_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the transceiver mode controller
// ----------------------------------------------------------------------------
package cxm_pkg;

    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;       // 25 MHz system clock
    localparam int T_WAKE_NS     = 1500;     // Longest driver wake time
    // Least wait, rounded up to whole cycles
    localparam int WAKE_CYC      = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W    = 6;        // Counter width for the wake wait
    localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CYC - 1);

    // ------------------------------------------------------------------------
    // Bit rates in search order; RATE_1M follows but the search never reaches it
    // ------------------------------------------------------------------------
    localparam logic [1:0]  RATE_IDX_FIRST = 2'h0;      // Search starts here
    localparam logic [1:0]  RATE_IDX_LAST  = 2'h2;      // Wraps after this one
    localparam logic [15:0] RATE_125K      = 16'h007D;  // 125 kbps
    localparam logic [15:0] RATE_250K      = 16'h00FA;  // 250 kbps
    localparam logic [15:0] RATE_500K      = 16'h01F4;  // 500 kbps
    localparam logic [15:0] RATE_1M        = 16'h03E8;  // Highest bus rate

    // ------------------------------------------------------------------------
    // Pin levels and reset values
    // ------------------------------------------------------------------------
    localparam logic LVL_RECESSIVE = 1'h1;   // Idle level on transmit/receive
    localparam logic LVL_DOMINANT  = 1'h0;
    localparam logic MODE_FAST     = 1'h0;   // Mode-select low: full speed
    localparam logic MODE_STANDBY  = 1'h1;   // Mode-select high: listen only
    localparam logic LOOP_OFF      = 1'h0;
    localparam logic LOOP_ON       = 1'h1;

    // ------------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CXM_NORMAL   = 2'b00,
        CXM_STANDBY  = 2'b01,
        CXM_WAKE     = 2'b10,
        CXM_AUTOBAUD = 2'b11
    } cxm_state_t;

    // One receive-line transition handed to the user
    typedef struct packed {
        logic level;          // Receive level after the transition
        logic dom_edge;       // Set when the transition went dominant
    } cxm_rx_evt_t;

endpackage

// file: cxm_dev_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Behavioural transceiver as the host sees it at its logic pins
// ----------------------------------------------------------------------------
module cxm_dev_model (
    input  wire logic txd,        // Transmit data from the host
    input  wire logic mode_sel,   // High selects listen-only standby
    input  wire logic loop_sel,   // High selects local loopback
    input  wire logic other_dom,  // Another node pulls the bus dominant
    output logic      rxd,        // Receive data to the host
    output logic      bus_dom     // Bus state, 1 = dominant
);
    logic loop_on;  // Loopback request seen after pull-down
    logic drv_en;   // Bus driver allowed to act

    // Open or floating pin reads low, so only a firm high counts
    assign loop_on = (loop_sel === 1'b1);
    // Driver off in standby or loopback; resistor makes no difference here
    assign drv_en = (mode_sel === 1'b0) && !loop_on;
    // Recessive unless a live driver or another node pulls it; no edge limit.
    // Overheat only trims drive current, so the logic level stays the same
    assign bus_dom = (drv_en && (txd === 1'b0)) ||
                     other_dom;

    // Receiver always listens; loopback adds the local transmit data
    always_comb begin
        if (loop_on) begin
            rxd = !(bus_dom || (txd === 1'b0));
        end else begin
            rxd = !bus_dom;
        end
    end
endmodule // cxm_dev_model

// file: cxm_host_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Testbench for the transceiver mode controller
// ----------------------------------------------------------------------------
module cxm_host_tb_top;
    logic                 clk;             // 25 MHz clock
    logic                 rst;             // Async reset
    logic                 tx_bit;          // Engine transmit bit
    logic                 standby_req;     // Standby pulse
    logic                 wake_req;        // Software wake pulse
    logic                 wake_on_bus;     // Bus wake enable
    logic                 autobaud_start;  // Search start pulse
    logic                 msg_ok;          // Good message pulse
    logic                 err_warn;        // Error warning pulse
    logic                 rx_evt_ready;    // Event consumer ready
    logic                 other_dom;       // Remote node dominant
    logic                 txd;             // Transmit pin
    logic                 mode_sel;        // Mode-select pin
    logic                 loop_sel;        // Loopback pin
    logic                 tx_ready;        // Transmit passes
    logic [1:0]           rate_idx;        // Candidate index
    logic [15:0]          rate_kbps;       // Candidate rate
    logic                 rate_locked;     // Search done
    cxm_pkg::cxm_state_t  state;           // Controller state
    logic                 rx_evt_valid;    // Event waiting
    cxm_pkg::cxm_rx_evt_t rx_evt;          // Event contents
    logic                 rxd;             // Receive pin
    logic                 bus_dom;         // Bus dominant
    int                   fail_count;      // Mismatches
    int                   comparisons;     // Checks made

    cxm_host u_dut (.CLK(clk), .RST(rst), .TX_BIT(tx_bit), .STANDBY_REQ(standby_req),
        .WAKE_REQ(wake_req), .WAKE_ON_BUS(wake_on_bus), .AUTOBAUD_START(autobaud_start),
        .MSG_OK(msg_ok), .ERR_WARN(err_warn), .RXD(rxd), .RX_EVT_READY(rx_evt_ready),
        .TXD(txd), .MODE_SELECT_IN(mode_sel), .AUTOBAUD_LOOP_SELECT_IN(loop_sel),
        .TX_READY(tx_ready), .RATE_IDX(rate_idx), .RATE_KBPS(rate_kbps),
        .RATE_LOCKED(rate_locked), .STATE(state), .RX_EVT_VALID(rx_evt_valid), .RX_EVT(rx_evt));
    cxm_dev_model u_dev (.txd(txd), .mode_sel(mode_sel), .loop_sel(loop_sel),
        .other_dom(other_dom), .rxd(rxd), .bus_dom(bus_dom));

    // ------------------------------------------------------------------------
    // Clock and shared helpers
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Count and report one comparison
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // Counts, verdict, end of run
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Wake lasts a fixed count, transmit held off meanwhile
    task automatic count_wake();
        int n;
        n = 0;
        chk("state wake", 16'(cxm_pkg::CXM_WAKE), 16'(state));
        chk("mode pin wake", 16'h0000, 16'(mode_sel));
        while (state === cxm_pkg::CXM_WAKE && n < 100) begin
            chk("txd in wake", 16'h0001, 16'(txd));
            n++;
            @(negedge clk);
        end
        chk("wake cycles", 16'(cxm_pkg::WAKE_CYC), 16'(n));
        chk("state after wake", 16'(cxm_pkg::CXM_NORMAL), 16'(state));
        chk("driver back", 16'(!tx_bit), 16'(bus_dom));
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        chk("txd in reset", 16'h0001, 16'(txd));
        chk("kbps in reset", cxm_pkg::RATE_125K, rate_kbps);
        chk("loop pin in reset", 16'h0000, 16'(loop_sel));
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("tx_ready", 16'h0001, 16'(tx_ready));
        tx_bit = 1'b0;
        @(negedge clk);
        chk("bus driven", 16'h0001, 16'(bus_dom));
        tx_bit = 1'b1;
        @(negedge clk);
        chk("bus released", 16'h0000, 16'(bus_dom));
        $display("test reset done");
    endtask

    task automatic t_standby();
        standby_req = 1'b1;
        tx_bit = 1'b0;
        @(negedge clk);
        standby_req = 1'b0;
        chk("mode pin standby", 16'h0001, 16'(mode_sel));
        chk("bus in standby", 16'h0000, 16'(bus_dom));
        other_dom = 1'b1;
        repeat (3) @(negedge clk);
        chk("rxd in standby", 16'h0000, 16'(rxd));
        chk("no bus wake", 16'(cxm_pkg::CXM_STANDBY), 16'(state));
        other_dom = 1'b0;
        wake_req = 1'b1;
        @(negedge clk);
        wake_req = 1'b0;
        count_wake();
        standby_req = 1'b1;
        @(negedge clk);
        standby_req = 1'b0;
        wake_on_bus = 1'b1;
        // Let the recessive level be taken first, or no falling edge exists
        @(negedge clk);
        other_dom = 1'b1;
        @(negedge clk);
        other_dom = 1'b0;
        count_wake();
        tx_bit = 1'b1;
        wake_on_bus = 1'b0;
        $display("test standby done");
    endtask

    task automatic t_autobaud();
        logic [15:0] rates [3];
        rates = '{cxm_pkg::RATE_125K, cxm_pkg::RATE_250K, cxm_pkg::RATE_500K};
        autobaud_start = 1'b1;
        @(negedge clk);
        autobaud_start = 1'b0;
        chk("loop pin", 16'h0001, 16'(loop_sel));
        chk("first rate", cxm_pkg::RATE_125K, rate_kbps);
        chk("locked cleared", 16'h0000, 16'(rate_locked));
        tx_bit = 1'b0;
        @(negedge clk);
        chk("bus in loop", 16'h0000, 16'(bus_dom));
        chk("rxd looped", 16'h0000, 16'(rxd));
        tx_bit = 1'b1;
        other_dom = 1'b1;
        @(negedge clk);
        chk("rxd from bus", 16'h0000, 16'(rxd));
        other_dom = 1'b0;
        for (int k = 1; k <= 4; k++) begin
            err_warn = 1'b1;
            @(negedge clk);
            err_warn = 1'b0;
            chk("rate step", rates[k % 3], rate_kbps);
        end
        msg_ok = 1'b1;
        err_warn = 1'b1;
        @(negedge clk);
        msg_ok = 1'b0;
        err_warn = 1'b0;
        chk("loop pin off", 16'h0000, 16'(loop_sel));
        chk("locked", 16'h0001, 16'(rate_locked));
        chk("rate kept", 16'h0001, 16'(rate_idx));
        tx_bit = 1'b0;
        @(negedge clk);
        chk("bus after search", 16'h0001, 16'(bus_dom));
        tx_bit = 1'b1;
        $display("test autobaud done");
    endtask

    task automatic t_buffer();
        logic [1:0] exp [3];
        int n;
        exp = '{2'b01, 2'b10, 2'b01};
        repeat (3) @(negedge clk);
        rx_evt_ready = 1'b0;
        for (int k = 0; k < 3; k++) begin
            other_dom = exp[k][0];
            repeat (2) @(negedge clk);
        end
        rx_evt_ready = 1'b1;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            while (rx_evt_valid !== 1'b1 && n < 4) begin
                @(negedge clk);
                n++;
            end
            chk("event", 16'(exp[k]), 16'(rx_evt));
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        chk("buffer empty", 16'h0000, 16'(rx_evt_valid));
        other_dom = 1'b0;
        $display("test buffer done");
    endtask

    // ------------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        fail_count = 0;
        comparisons = 0;
        rst = 1'b1;
        tx_bit = 1'b1;
        {standby_req, wake_req, wake_on_bus, autobaud_start} = 4'h0;
        {msg_ok, err_warn, other_dom} = 3'h0;
        rx_evt_ready = 1'b1;
        repeat (11) @(negedge clk);
        t_reset();
        t_standby();
        t_autobaud();
        t_buffer();
        wrap_up();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        $display("unexpected watchdog expected done seen running");
        fail_count++;
        wrap_up();
    end
endmodule // cxm_host_tb_top
